/* File: inc/tat_defs.vh */
`ifndef TAT_DEFS_VH
`define TAT_DEFS_VH
// register byte addresses
`define TAT_ADDR_CONTROL 16'h11D4
`define TAT_ADDR_STATUS 16'h11D8
`define TAT_ADDR_ALARM 16'h11DC
`define TAT_ADDR_IRQ_STAT 16'h11F0
`define TAT_ADDR_IRQ_MASK 16'h11F4
// field positions
`define TAT_TEMP_LSB 0
`define TAT_LOW_LSB 8
`define TAT_HIGH_LSB 16
`define TAT_FLAG_LSB 24
`define TAT_UPD_BIT 31
`define TAT_SENSOR_POWER_OFF_BIT 31
// reset values and write masks
`define TAT_LOW_RST 8'hFF
`define TAT_HIGH_RST 8'h00
`define TAT_CTL_RST 32'h80000000
`define TAT_CTL_MASK 32'hBFFFFFFF
`define TAT_ALARM_MASK 32'hBFFFFF00
// interrupt status bits
`define TAT_IRQ_SAMPLE 0
`define TAT_IRQ_THERM 1
`define TAT_IRQ_W 2
`endif

/* File: core/tat_sync.v */
`timescale 1ns/1ps
// two-stage synchroniser for a level from outside the clock domain
module tat_sync #(
   parameter W = 1
) (
   input wire clk, // clock
   input wire rst, // synchronous reset
   input wire [W-1:0] din, // asynchronous input
   output reg [W-1:0] dout // synchronised output
);
   reg [W-1:0] stage1;

   always @(posedge clk)
   begin
      if (rst)
      begin
         stage1 <= {W{1'b0}};
         dout <= {W{1'b0}};
      end
      else
      begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule

/* File: core/tat_compare.v */
`timescale 1ns/1ps
// compares one sample against one limit
module tat_compare (
   input wire [7:0] sample, // current reading
   input wire [7:0] limit, // threshold
   output wire below, // sample below limit
   output wire above // sample above limit
);
   assign below = (sample < limit);
   assign above = (sample > limit);
endmodule

/* File: core/tat_tracker.v */
// Overview of operation
// - current reading in status bits 7:0
// - status mirrors alarm fields
// - alarm 15:8 lowest reading, resets FF
// - alarm 23:16 highest reading, resets 0
// - writes load lowest and highest fields
// - bits 24/25 below/above low limit
// - bits 26/27 below/above mid limit
// - bits 28/29 below/above high limit
// - threshold flags clear on alarm read
// - writes force threshold flags to value
// - bit 31 set on each new sample
// - limits from control bits 7:0,15:8,23:16
// - enabled set flag raises thermal interrupt
// - power-off bit zeroes reading, reset set
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "tat_defs.vh"
module tat_tracker (
   input wire CLK_SYS, // 25 MHz clock
   input wire RST, // synchronous reset, active high
   input wire [15:0] ADDR, // register byte address
   input wire [31:0] WDATA, // write data
   input wire WR, // write strobe
   input wire RD, // read strobe
   output reg [31:0] RDATA, // read data, cycle after RD
   input wire [7:0] SENSOR_DATA, // raw reading from sensor
   input wire SENSOR_TOGGLE, // toggles once per new sample
   output reg SENSOR_POWER_OFF, // powers down analog sensor
   output reg THERMAL_IRQ_FLAG, // to bridge and ntb status
   output reg IRQ // level interrupt
);
   ////////////////////////////////////////////////////////////////////////
   reg [31:0] thermal_control;
   reg [7:0] current_reading;
   reg [7:0] lowest_reading;
   reg [7:0] highest_reading;
   reg [5:0] flags;
   reg updated;
   reg [`TAT_IRQ_W-1:0] irq_status;
   reg [`TAT_IRQ_W-1:0] irq_mask;
   reg toggle_d;
   wire [7:0] sensor_sync;
   wire toggle_sync;
   wire [7:0] low_limit;
   wire [7:0] mid_limit;
   wire [7:0] high_limit;
   wire [5:0] hit;
   wire sample_event;
   wire [7:0] sample;
   wire sensor_power_off;
   wire [31:0] thermal_alarm;
   wire [31:0] thermal_status;
   reg [5:0] next_flags;
   reg [7:0] next_lowest;
   reg [7:0] next_highest;
   reg next_updated;
   reg [`TAT_IRQ_W-1:0] next_irq_status;
   reg [31:0] next_rdata;
   wire wr_ctl;
   wire wr_alarm;
   wire rd_alarm;
   wire rd_irq;
   wire therm_req;

   ////////////////////////////////////////////////////////////////////////
   // sensor inputs come from the analog domain
   tat_sync #(.W(8)) u_sync_data (
      .clk(CLK_SYS),
      .rst(RST),
      .din(SENSOR_DATA),
      .dout(sensor_sync)
   );

   tat_sync #(.W(1)) u_sync_tog (
      .clk(CLK_SYS),
      .rst(RST),
      .din(SENSOR_TOGGLE),
      .dout(toggle_sync)
   );

   always @(posedge CLK_SYS)
   begin
      if (RST)
         toggle_d <= 1'b0;
      else
         toggle_d <= toggle_sync;
   end

   assign sensor_power_off = thermal_control[`TAT_SENSOR_POWER_OFF_BIT];
   // while powered off no samples are taken
   assign sample_event = (toggle_sync ^ toggle_d) & ~sensor_power_off;
   assign sample = sensor_sync;

   ////////////////////////////////////////////////////////////////////////
   assign low_limit = thermal_control[7:0];
   assign mid_limit = thermal_control[15:8];
   assign high_limit = thermal_control[23:16];

   tat_compare u_cmp_low (
      .sample(sample),
      .limit(low_limit),
      .below(hit[0]),
      .above(hit[1])
   );

   tat_compare u_cmp_mid (
      .sample(sample),
      .limit(mid_limit),
      .below(hit[2]),
      .above(hit[3])
   );

   tat_compare u_cmp_high (
      .sample(sample),
      .limit(high_limit),
      .below(hit[4]),
      .above(hit[5])
   );

   ////////////////////////////////////////////////////////////////////////
   // address decode
   assign wr_ctl = WR && (ADDR == `TAT_ADDR_CONTROL);
   assign wr_alarm = WR && (ADDR == `TAT_ADDR_ALARM);
   assign rd_alarm = RD && (ADDR == `TAT_ADDR_ALARM);
   assign rd_irq = RD && (ADDR == `TAT_ADDR_IRQ_STAT);

   assign thermal_alarm = {updated, 1'b0, flags, highest_reading,
                           lowest_reading, 8'h00};
   // status mirrors the alarm fields live
   assign thermal_status = {thermal_alarm[31:8], current_reading};

   ////////////////////////////////////////////////////////////////////////
   // alarm next state: write applies first, then a new sample on top,
   // so a sample landing with a write or read is never lost
   always @*
   begin
      next_flags = flags;
      next_lowest = lowest_reading;
      next_highest = highest_reading;
      next_updated = updated;
      if (rd_alarm)
      begin
         next_flags = 6'h00;
         next_updated = 1'b0;
      end
      if (wr_alarm)
      begin
         next_lowest = WDATA[15:8];
         next_highest = WDATA[23:16];
         next_flags = WDATA[29:24];
         next_updated = updated & ~WDATA[`TAT_UPD_BIT];
      end
      if (sample_event)
      begin
         next_flags = next_flags | hit;
         next_updated = 1'b1;
         if (sample < next_lowest)
            next_lowest = sample;
         if (sample > next_highest)
            next_highest = sample;
      end
   end

   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         lowest_reading <= `TAT_LOW_RST;
         highest_reading <= `TAT_HIGH_RST;
         flags <= 6'h00;
         updated <= 1'b0;
         current_reading <= 8'h00;
      end
      else
      begin
         lowest_reading <= next_lowest;
         highest_reading <= next_highest;
         flags <= next_flags;
         updated <= next_updated;
         if (sensor_power_off)
            current_reading <= 8'h00;
         else if (sample_event)
            current_reading <= sample;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register
   always @(posedge CLK_SYS)
   begin
      if (RST)
         thermal_control <= `TAT_CTL_RST;
      else if (wr_ctl)
         thermal_control <= WDATA & `TAT_CTL_MASK;
   end

   assign therm_req = |(flags & thermal_control[29:24]);

   ////////////////////////////////////////////////////////////////////////
   // local interrupt: sticky status cleared by read, set wins
   always @*
   begin
      next_irq_status = irq_status;
      if (rd_irq)
         next_irq_status = {`TAT_IRQ_W{1'b0}};
      if (sample_event)
         next_irq_status[`TAT_IRQ_SAMPLE] = 1'b1;
      if (therm_req)
         next_irq_status[`TAT_IRQ_THERM] = 1'b1;
   end

   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         irq_status <= {`TAT_IRQ_W{1'b0}};
         irq_mask <= {`TAT_IRQ_W{1'b0}};
      end
      else
      begin
         irq_status <= next_irq_status;
         if (WR && (ADDR == `TAT_ADDR_IRQ_MASK))
            irq_mask <= WDATA[`TAT_IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux
   always @*
   begin
      next_rdata = 32'h00000000;
      if (ADDR == `TAT_ADDR_CONTROL)
         next_rdata = thermal_control;
      else if (ADDR == `TAT_ADDR_STATUS)
         next_rdata = thermal_status;
      else if (ADDR == `TAT_ADDR_ALARM)
         next_rdata = thermal_alarm;
      else if (ADDR == `TAT_ADDR_IRQ_STAT)
         next_rdata = {30'h00000000, irq_status};
      else if (ADDR == `TAT_ADDR_IRQ_MASK)
         next_rdata = {30'h00000000, irq_mask};
   end

   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         RDATA <= 32'h00000000;
         SENSOR_POWER_OFF <= 1'b1;
         THERMAL_IRQ_FLAG <= 1'b0;
         IRQ <= 1'b0;
      end
      else
      begin
         RDATA <= RD ? next_rdata : 32'h00000000;
         SENSOR_POWER_OFF <= sensor_power_off;
         THERMAL_IRQ_FLAG <= therm_req;
         IRQ <= |(next_irq_status & irq_mask);
      end
   end
endmodule

/* File: sim/tat_checker_sva.sv */
`timescale 1ns/1ps
module tat_checker (
   input wire logic CLK_SYS, // clock
   input wire logic RST, // reset
   input wire logic [15:0] ADDR, // address
   input wire logic [31:0] WDATA, // write data
   input wire logic WR, // write strobe
   input wire logic RD, // read strobe
   input wire logic [31:0] RDATA, // read data
   input wire logic SENSOR_TOGGLE, // sample toggle
   input wire logic SENSOR_POWER_OFF, // sensor off
   input wire logic THERMAL_IRQ_FLAG, // thermal request
   input wire logic IRQ // interrupt
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data outside answer cycle");
   AST_STS_RSV: assert property ($past(RD && ADDR == 16'h11D8) |->
      !RDATA[30]) else $error("status bit 30 set");
   AST_ALM_RSV: assert property ($past(RD && ADDR == 16'h11DC) |->
      RDATA[7:0] == 8'h00 && !RDATA[30]) else $error("alarm reserved set");
   AST_OFF_ZERO: assert property ($past(RD && ADDR == 16'h11D8 &&
      SENSOR_POWER_OFF) |-> RDATA[7:0] == 8'h00)
      else $error("reading not zero while off");
   AST_OFF_RST: assert property ($fell(RST) |-> SENSOR_POWER_OFF)
      else $error("sensor on after reset");
   AST_CTL_WR: assert property (WR && ADDR == 16'h11D4 |-> ##2
      SENSOR_POWER_OFF == $past(WDATA[31], 2)) else $error("power bit");
   AST_THERM: assert property ($rose(THERMAL_IRQ_FLAG) |-> $past(WR) ||
      $past(WR, 2) || $past(SENSOR_TOGGLE, 4) != $past(SENSOR_TOGGLE, 5))
      else $error("thermal request without cause");
   AST_IRQ: assert property ($rose(IRQ) |-> $past(WR) || $past(WR, 2) ||
      $past(SENSOR_TOGGLE, 3) != $past(SENSOR_TOGGLE, 4))
      else $error("interrupt without cause");
endmodule
bind tat_tracker tat_checker u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .SENSOR_TOGGLE(SENSOR_TOGGLE), .SENSOR_POWER_OFF(SENSOR_POWER_OFF),
   .THERMAL_IRQ_FLAG(THERMAL_IRQ_FLAG), .IRQ(IRQ));

/* File: sim/tat_sensor_model.sv */
`timescale 1ns/1ps
module tat_sensor_model (
   input wire logic clk, // clock
   output logic [7:0] data, // reading
   output logic toggle // flips once per sample
);
   initial
   begin
      data = 8'h00;
      toggle = 1'b0;
   end
   // reading settles before the toggle and stays after it
   task send(input logic [7:0] v);
      @(posedge clk);
      data <= v;
      repeat (2) @(posedge clk);
      toggle <= ~toggle;
      repeat (6) @(posedge clk);
   endtask
endmodule

/* File: sim/tat_tracker_test.sv */
`timescale 1ns/1ps
module tat_tracker_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [7:0] s_data;
   logic s_tog, pwr_off, therm, irq;
   int num_errors = 0;
   int n_checks = 0;
   always #20 clk = ~clk;
   tat_tracker u_tat_tracker (.CLK_SYS(clk), .RST(rst), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .SENSOR_DATA(s_data), .SENSOR_TOGGLE(s_tog),
      .SENSOR_POWER_OFF(pwr_off), .THERMAL_IRQ_FLAG(therm), .IRQ(irq));
   tat_sensor_model sensor (.clk(clk), .data(s_data), .toggle(s_tog));
   ////////////////////////////////////////////////////////////////////////
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task bus_wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task bus_rd(input logic [15:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check($sformatf("read %h", a), rdata, e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      bus_rd(16'h11D8, 32'h0000FF00);
      bus_rd(16'h11DC, 32'h0000FF00);
      bus_rd(16'h11D4, 32'h80000000);
      bus_rd(16'h0000, 32'h0);
      check("power_off", pwr_off, 1'b1);
      $display("t_reset done");
   endtask
   task t_sample;
      bus_wr(16'h11D4, 32'h3F604020);
      sensor.send(8'h50);
      check("irq masked", irq, 1'b0);
      bus_rd(16'h11D8, 32'h9A505050);
      check("therm", therm, 1'b1);
      bus_wr(16'h11F4, 32'h1);
      repeat (2) @(posedge clk);
      #1 check("irq", irq, 1'b1);
      bus_rd(16'h11F0, 32'h3);
      @(posedge clk);
      #1 check("irq clear", irq, 1'b0);
      bus_rd(16'h11DC, 32'h9A505000);
      bus_rd(16'h11DC, 32'h00505000);
      @(posedge clk);
      #1 check("therm clear", therm, 1'b0);
      sensor.send(8'h10);
      sensor.send(8'h70);
      bus_rd(16'h11DC, 32'hBF701000);
      sensor.send(8'h40);
      bus_rd(16'h11D8, 32'h92701040);
      $display("t_sample done");
   endtask
   task t_write;
      bus_wr(16'h11D4, 32'h80000000);
      bus_wr(16'h11DC, 32'h95AA3300);
      bus_rd(16'h11D8, 32'h15AA3300);
      sensor.send(8'h20);
      bus_wr(16'h11D8, 32'hFFFFFFFF);
      bus_rd(16'h11D8, 32'h15AA3300);
      $display("t_write done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (2000) @(posedge clk);
      num_errors++;
      print_verdict;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_sample;
      t_write;
      print_verdict;
   end
endmodule
